// File: hw/shdf_defs.svh
`ifndef SHDF_DEFS_SVH
`define SHDF_DEFS_SVH
// Summary of operation
// R1: Hold mode keeps a valid channel sense value on the output after switch-off.
// R2: After turn-on, sense is accurate only once the sync signal falls.
// R3: At switch-off in hold mode, capture last value, hold it, raise sync.
// R4: Changing the sensed source clears the held value and reacquires.
// R5: Controller cycles the channel off and on after temperature sensing in hold mode.
// R6: Controller avoids hold mode below 60 Hz channel switching.
// R7: Offset polarity bit D8: 1 adds the random offset, 0 subtracts it.
// R8: Controller averages two measurements taken with opposite offset polarity.
// R9: Held value keeps the polarity active at switch-off until the next on period.
// R10: Controller spaces compensation measurements about five filter time constants.
// R11: In normal mode, over-threshold temperature sets prewarning bit; channel stays on.
// R12: Prewarning stays set until fault register is read with temperature below threshold.
// R13: On-state bits follow each output's above-half-supply comparator in real time.
// R14: On-state bits may differ from the internal on-control at low supply.
// R15: Hold enable 0 (default) selects synchronous mode, 1 selects hold mode.
// R16: Two select bits choose channel 0, channel 1 or temperature for sensing.
// R17: During an overcurrent window, sensing is off and sync stays high.

// =====================================
// Register map (byte addresses)
`define SHDF_GCFG_ADDR 8'h00
`define SHDF_RETRY0_ADDR 8'h04
`define SHDF_RETRY1_ADDR 8'h08
`define SHDF_FAULT_ADDR 8'h0C
`define SHDF_STATUS_ADDR 8'h10
`define SHDF_SENSE_ADDR 8'h14

// =====================================
// Field positions
`define SHDF_GCFG_SEL_LO 0
`define SHDF_GCFG_SEL_HI 1
`define SHDF_GCFG_TH_EN 2
`define SHDF_RETRY_OFP 8
`define SHDF_FAULT_OTW 8
`define SHDF_STAT_SYNC 2

// =====================================
// Codes and reset values
`define SHDF_SEL_NONE 2'h0
`define SHDF_SEL_CH0 2'h1
`define SHDF_SEL_CH1 2'h2
`define SHDF_SEL_TEMP 2'h3
`define SHDF_GCFG_RST 3'h0
`define SHDF_RESP_OKAY 2'h0
`define SHDF_RESP_SLVERR 2'h2

// =====================================
// Timing
`define SHDF_CLK_MHZ 10
`define SHDF_SETTLE_US 20
`endif

// File: hw/shdf_pkg.sv
package shdf_pkg;
	typedef enum logic [1:0]
	{
		SHDF_IDLE = 2'h0,
		SHDF_SETTLE = 2'h1,
		SHDF_TRACK = 2'h3,
		SHDF_HOLD = 2'h2
	} shdf_state_t;
endpackage

// File: hw/shdf_sense_if.sv
`timescale 1ns/10ps
interface shdf_sense_if #(parameter int SW = 12);
	logic th_en;
	logic [1:0] sel;
	logic [1:0] ch_on;
	logic [1:0] oc_win;
	logic [1:0] ofs_pol;
	logic [SW-1:0] cur0;
	logic [SW-1:0] cur1;
	logic [SW-1:0] temp;
	logic [SW-1:0] rand_off;
	logic [SW-1:0] sense_val;
	logic sense_sync;
	shdf_pkg::shdf_state_t eng_state;
	modport ctl (output th_en, sel, ch_on, oc_win, ofs_pol, cur0, cur1, temp, rand_off,
		input sense_val, sense_sync, eng_state);
	modport eng (input th_en, sel, ch_on, oc_win, ofs_pol, cur0, cur1, temp, rand_off,
		output sense_val, sense_sync, eng_state);
endinterface

// File: hw/shdf_sync.sv
`timescale 1ns/10ps
module shdf_sync #(parameter int W = 8)
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Data
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	typedef struct packed
	{
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} shdf_sync_st_t;

	shdf_sync_st_t r_q;
	shdf_sync_st_t r_d;

	// Output moves only when two late stages agree, filtering a stage caught mid-change
	always_comb
	begin
		r_d = r_q;
		r_d.s1 = i_d;
		r_d.s2 = r_q.s1;
		r_d.s3 = r_q.s2;
		if (r_q.s2 == r_q.s3)
		begin
			r_d.q = r_q.s3;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			r_q <= '0;
		end
		else
		begin
			r_q <= r_d;
		end
	end

	assign o_q = r_q.q;
endmodule

// File: hw/shdf_hold.sv
`timescale 1ns/10ps
`include "shdf_defs.svh"
module shdf_hold #(
	parameter int SW = 12,
	parameter int SETTLE_CYC = `SHDF_SETTLE_US * `SHDF_CLK_MHZ
)
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Sense path
	shdf_sense_if.eng sb
);
	localparam int CW = $clog2(SETTLE_CYC + 1);

	typedef struct packed
	{
		shdf_pkg::shdf_state_t st;
		logic [CW-1:0] cnt;
		logic [1:0] sel;
		logic [SW-1:0] val;
		logic sync;
	} shdf_hold_st_t;

	localparam shdf_hold_st_t RST = '{st: shdf_pkg::SHDF_IDLE, cnt: '0,
		sel: `SHDF_SEL_NONE, val: '0, sync: 1'b1};

	shdf_hold_st_t r_q;
	shdf_hold_st_t r_d;

	always_comb
	begin
		logic on;
		logic oc;
		logic pol;
		logic [SW-1:0] cur;
		logic [SW:0] wide;
		logic [SW-1:0] meas;
		on = 1'b0;
		oc = 1'b0;
		pol = 1'b0;
		cur = '0;
		wide = '0;
		meas = '0;
		r_d = r_q;
		// R16: source select
		case (sb.sel)
			`SHDF_SEL_CH0:
			begin
				on = sb.ch_on[0];
				oc = sb.oc_win[0];
				pol = sb.ofs_pol[0];
				cur = sb.cur0;
			end
			`SHDF_SEL_CH1:
			begin
				on = sb.ch_on[1];
				oc = sb.oc_win[1];
				pol = sb.ofs_pol[1];
				cur = sb.cur1;
			end
			default:
			begin
				on = 1'b0;
			end
		endcase
		// R7: polarity adds or subtracts offset, saturating at the rails
		if (pol)
		begin
			wide = {1'b0, cur} + {1'b0, sb.rand_off};
			meas = wide[SW] ? '1 : wide[SW-1:0];
		end
		else
		begin
			wide = {1'b0, cur} - {1'b0, sb.rand_off};
			meas = wide[SW] ? '0 : wide[SW-1:0];
		end
		r_d.sel = sb.sel;
		if (sb.sel != r_q.sel)
		begin
			// R4: source change drops held value
			r_d.st = shdf_pkg::SHDF_IDLE;
			r_d.val = '0;
			r_d.sync = 1'b1;
		end
		else if (sb.sel == `SHDF_SEL_TEMP)
		begin
			r_d.st = shdf_pkg::SHDF_IDLE;
			r_d.val = sb.temp;
			r_d.sync = 1'b1;
		end
		else if (sb.sel == `SHDF_SEL_NONE || oc)
		begin
			// R17: sensing off in overcurrent window
			r_d.st = shdf_pkg::SHDF_IDLE;
			r_d.val = '0;
			r_d.sync = 1'b1;
		end
		else
		begin
			case (r_q.st)
				shdf_pkg::SHDF_IDLE:
				begin
					r_d.val = '0;
					r_d.sync = 1'b1;
					if (on)
					begin
						r_d.st = shdf_pkg::SHDF_SETTLE;
						r_d.cnt = '0;
					end
				end
				shdf_pkg::SHDF_SETTLE:
				begin
					// R2: sync stays high until settled; hold mode keeps old sample meanwhile
					r_d.sync = 1'b1;
					r_d.val = sb.th_en ? r_q.val : meas;
					r_d.cnt = r_q.cnt + CW'(1);
					if (!on)
					begin
						r_d.st = sb.th_en ? shdf_pkg::SHDF_HOLD : shdf_pkg::SHDF_IDLE;
						r_d.val = sb.th_en ? r_q.val : '0;
					end
					else if (r_q.cnt == CW'(SETTLE_CYC - 1))
					begin
						r_d.st = shdf_pkg::SHDF_TRACK;
						r_d.cnt = '0;
					end
				end
				shdf_pkg::SHDF_TRACK:
				begin
					r_d.val = meas;
					r_d.sync = 1'b0;
					if (!on)
					begin
						// R15: mode decides whether switch-off holds or drops
						if (sb.th_en)
						begin
							// R3: last tracked sample held, sync raised
							r_d.st = shdf_pkg::SHDF_HOLD;
							r_d.val = r_q.val;
							r_d.sync = 1'b1;
						end
						else
						begin
							r_d.st = shdf_pkg::SHDF_IDLE;
							r_d.val = '0;
							r_d.sync = 1'b1;
						end
					end
				end
				shdf_pkg::SHDF_HOLD:
				begin
					// R1: held value stays; R9: polarity changes ignored while off
					r_d.sync = 1'b1;
					if (!sb.th_en)
					begin
						r_d.st = shdf_pkg::SHDF_IDLE;
						r_d.val = '0;
					end
					else if (on)
					begin
						r_d.st = shdf_pkg::SHDF_SETTLE;
						r_d.cnt = '0;
					end
				end
				default:
				begin
					r_d = RST;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			r_q <= RST;
		end
		else
		begin
			r_q <= r_d;
		end
	end

	assign sb.sense_val = r_q.val;
	assign sb.sense_sync = r_q.sync;
	assign sb.eng_state = r_q.st;
endmodule

// File: hw/shdf_top.sv
// Added by the designer: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
`include "shdf_defs.svh"
module shdf_top #(
	parameter int SW = 12,
	parameter int AW = 8,
	parameter int SETTLE_CYC = `SHDF_SETTLE_US * `SHDF_CLK_MHZ
)
(
	// Clock and reset
	input wire logic I_CLK_SYS,
	input wire logic I_RSTN,
	// AXI4-Lite write
	input wire logic [AW-1:0] I_AWADDR,
	input wire logic I_AWVALID,
	output logic O_AWREADY,
	input wire logic [31:0] I_WDATA,
	input wire logic [3:0] I_WSTRB,
	input wire logic I_WVALID,
	output logic O_WREADY,
	output logic [1:0] O_BRESP,
	output logic O_BVALID,
	input wire logic I_BREADY,
	// AXI4-Lite read
	input wire logic [AW-1:0] I_ARADDR,
	input wire logic I_ARVALID,
	output logic O_ARREADY,
	output logic [31:0] O_RDATA,
	output logic [1:0] O_RRESP,
	output logic O_RVALID,
	input wire logic I_RREADY,
	// Channel and analog front end
	input wire logic [1:0] I_CH_ON,
	input wire logic [1:0] I_OUT_HI,
	input wire logic [1:0] I_OC_WIN,
	input wire logic I_TEMP_HI,
	input wire logic I_NORMAL_MODE,
	input wire logic [SW-1:0] I_CUR0,
	input wire logic [SW-1:0] I_CUR1,
	input wire logic [SW-1:0] I_TEMP_CODE,
	input wire logic [SW-1:0] I_RAND_OFFSET,
	// Sense output
	output logic [SW-1:0] O_SENSE_CODE,
	output logic O_SENSE_SYNC,
	output logic [1:0] O_OFFSET_POLARITY
);
	localparam int YW = 8 + 4 * SW;

	typedef struct packed
	{
		logic awrdy;
		logic wrdy;
		logic aw_have;
		logic w_have;
		logic [AW-1:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic arrdy;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [2:0] gcfg;
		logic [1:0] offset_polarity_bit;
		logic temp_prewarning_flag;
		logic [1:0] on_st;
		logic [SW-1:0] sense;
		logic sync;
	} shdf_top_st_t;

	// =====================================
	// Reset release
	logic [1:0] rst_sync_q;
	logic rst_n;

	always_ff @(posedge I_CLK_SYS or negedge I_RSTN)
	begin
		if (!I_RSTN)
		begin
			rst_sync_q <= 2'h0;
		end
		else
		begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end

	assign rst_n = rst_sync_q[1];

	// =====================================
	// Pin synchronisers
	logic [YW-1:0] pins;
	logic [YW-1:0] pins_s;
	logic normal_s;
	logic temp_hi_s;
	logic [1:0] oc_s;
	logic [1:0] out_hi_s;
	logic [1:0] ch_on_s;
	logic [SW-1:0] off_s;
	logic [SW-1:0] temp_s;
	logic [SW-1:0] cur1_s;
	logic [SW-1:0] cur0_s;

	assign pins = {I_NORMAL_MODE, I_TEMP_HI, I_OC_WIN, I_OUT_HI, I_CH_ON,
		I_RAND_OFFSET, I_TEMP_CODE, I_CUR1, I_CUR0};

	shdf_sync #(.W(YW)) u_sync
	(
		.i_clk(I_CLK_SYS),
		.i_rst_n(rst_n),
		.i_d(pins),
		.o_q(pins_s)
	);

	assign {normal_s, temp_hi_s, oc_s, out_hi_s, ch_on_s, off_s, temp_s, cur1_s, cur0_s} = pins_s;

	// =====================================
	// Sense engine
	shdf_top_st_t r_q;
	shdf_top_st_t r_d;

	shdf_sense_if #(.SW(SW)) sense_bus ();

	assign sense_bus.th_en = r_q.gcfg[`SHDF_GCFG_TH_EN];
	assign sense_bus.sel = {r_q.gcfg[`SHDF_GCFG_SEL_HI], r_q.gcfg[`SHDF_GCFG_SEL_LO]};
	assign sense_bus.ch_on = ch_on_s;
	assign sense_bus.oc_win = oc_s;
	assign sense_bus.ofs_pol = r_q.offset_polarity_bit;
	assign sense_bus.cur0 = cur0_s;
	assign sense_bus.cur1 = cur1_s;
	assign sense_bus.temp = temp_s;
	assign sense_bus.rand_off = off_s;

	shdf_hold #(.SW(SW), .SETTLE_CYC(SETTLE_CYC)) u_hold
	(
		.i_clk(I_CLK_SYS),
		.i_rst_n(rst_n),
		.sb(sense_bus.eng)
	);

	// =====================================
	// Register slave and flags
	always_comb
	begin
		logic [31:0] rd;
		logic [1:0] rr;
		logic otw_set;
		logic otw_clr;
		rd = 32'h0000_0000;
		rr = `SHDF_RESP_OKAY;
		otw_set = 1'b0;
		otw_clr = 1'b0;
		r_d = r_q;
		case (I_ARADDR)
			AW'(`SHDF_GCFG_ADDR):
			begin
				rd[2:0] = r_q.gcfg;
			end
			AW'(`SHDF_RETRY0_ADDR):
			begin
				rd[`SHDF_RETRY_OFP] = r_q.offset_polarity_bit[0];
			end
			AW'(`SHDF_RETRY1_ADDR):
			begin
				rd[`SHDF_RETRY_OFP] = r_q.offset_polarity_bit[1];
			end
			AW'(`SHDF_FAULT_ADDR):
			begin
				rd[`SHDF_FAULT_OTW] = r_q.temp_prewarning_flag;
				// R12: read clears only once temperature is back below threshold
				otw_clr = I_ARVALID && r_q.arrdy && !temp_hi_s;
			end
			AW'(`SHDF_STATUS_ADDR):
			begin
				rd[1:0] = r_q.on_st;
				rd[`SHDF_STAT_SYNC] = r_q.sync;
			end
			AW'(`SHDF_SENSE_ADDR):
			begin
				rd[SW-1:0] = r_q.sense;
			end
			default:
			begin
				rr = `SHDF_RESP_SLVERR;
			end
		endcase
		// Read channel
		if (r_q.rvalid && I_RREADY)
		begin
			r_d.rvalid = 1'b0;
		end
		if (I_ARVALID && r_q.arrdy)
		begin
			r_d.rvalid = 1'b1;
			r_d.rdata = rd;
			r_d.rresp = rr;
		end
		r_d.arrdy = !r_d.rvalid;
		// Write channel: address and data taken in either order
		if (r_q.bvalid && I_BREADY)
		begin
			r_d.bvalid = 1'b0;
		end
		if (I_AWVALID && r_q.awrdy)
		begin
			r_d.aw_have = 1'b1;
			r_d.awaddr = I_AWADDR;
		end
		if (I_WVALID && r_q.wrdy)
		begin
			r_d.w_have = 1'b1;
			r_d.wdata = I_WDATA;
			r_d.wstrb = I_WSTRB;
		end
		if (r_q.aw_have && r_q.w_have && !r_q.bvalid)
		begin
			r_d.aw_have = 1'b0;
			r_d.w_have = 1'b0;
			r_d.bvalid = 1'b1;
			r_d.bresp = `SHDF_RESP_OKAY;
			case (r_q.awaddr)
				AW'(`SHDF_GCFG_ADDR):
				begin
					// R15: hold enable and R16: select bits
					if (r_q.wstrb[0])
					begin
						r_d.gcfg = r_q.wdata[2:0];
					end
				end
				AW'(`SHDF_RETRY0_ADDR):
				begin
					// R7: per-channel polarity
					if (r_q.wstrb[1])
					begin
						r_d.offset_polarity_bit[0] = r_q.wdata[`SHDF_RETRY_OFP];
					end
				end
				AW'(`SHDF_RETRY1_ADDR):
				begin
					if (r_q.wstrb[1])
					begin
						r_d.offset_polarity_bit[1] = r_q.wdata[`SHDF_RETRY_OFP];
					end
				end
				AW'(`SHDF_FAULT_ADDR), AW'(`SHDF_STATUS_ADDR), AW'(`SHDF_SENSE_ADDR):
				begin
					r_d.bresp = `SHDF_RESP_OKAY;
				end
				default:
				begin
					r_d.bresp = `SHDF_RESP_SLVERR;
				end
			endcase
		end
		// Readiness withheld while a beat waits, so one write at a time
		r_d.awrdy = !r_d.aw_have && !r_d.bvalid;
		r_d.wrdy = !r_d.w_have && !r_d.bvalid;
		// R11: prewarning set in normal mode only; set beats a same-cycle clear
		otw_set = normal_s && temp_hi_s;
		r_d.temp_prewarning_flag = (r_q.temp_prewarning_flag && !otw_clr) || otw_set;
		// R13: comparator state, not on-control; R14: the two may differ
		r_d.on_st = out_hi_s;
		r_d.sense = sense_bus.sense_val;
		r_d.sync = sense_bus.sense_sync;
	end

	always_ff @(posedge I_CLK_SYS or negedge rst_n)
	begin
		if (!rst_n)
		begin
			r_q <= '0;
			r_q.gcfg <= `SHDF_GCFG_RST;
			r_q.sync <= 1'b1;
		end
		else
		begin
			r_q <= r_d;
		end
	end

	assign O_AWREADY = r_q.awrdy;
	assign O_WREADY = r_q.wrdy;
	assign O_BRESP = r_q.bresp;
	assign O_BVALID = r_q.bvalid;
	assign O_ARREADY = r_q.arrdy;
	assign O_RDATA = r_q.rdata;
	assign O_RRESP = r_q.rresp;
	assign O_RVALID = r_q.rvalid;
	assign O_SENSE_CODE = r_q.sense;
	assign O_SENSE_SYNC = r_q.sync;
	assign O_OFFSET_POLARITY = r_q.offset_polarity_bit;
endmodule

// File: test/shdf_top_assertions.sv
`timescale 1ns/10ps
// ====================
// Port checker
module shdf_top_assertions #(parameter int SW = 12)
(
	// Clock and reset
	input wire logic I_CLK_SYS,
	input wire logic I_RSTN,
	// Bus
	input wire logic I_AWVALID,
	input wire logic O_AWREADY,
	input wire logic I_WVALID,
	input wire logic O_WREADY,
	input wire logic O_BVALID,
	input wire logic I_ARVALID,
	input wire logic O_ARREADY,
	input wire logic O_RVALID,
	input wire logic I_RREADY,
	// Sense
	input wire logic [1:0] I_CH_ON,
	input wire logic [1:0] I_OC_WIN,
	input wire logic [1:0] O_OFFSET_POLARITY,
	input wire logic [SW-1:0] O_SENSE_CODE,
	input wire logic O_SENSE_SYNC
);
	default clocking cb @(posedge I_CLK_SYS);
	endclocking
	default disable iff (!I_RSTN);
	property p_r_ans;
		I_ARVALID && O_ARREADY |=> O_RVALID;
	endproperty
	a_r_ans: assert property (p_r_ans) else $error("read answer late");
	property p_r_done;
		O_RVALID && I_RREADY |=> !O_RVALID;
	endproperty
	a_r_done: assert property (p_r_done) else $error("read answer repeated");
	property p_ar_block;
		O_RVALID |-> !O_ARREADY;
	endproperty
	a_ar_block: assert property (p_ar_block) else $error("read address open early");
	property p_b_ans;
		I_AWVALID && O_AWREADY && I_WVALID && O_WREADY |-> ##2 O_BVALID;
	endproperty
	a_b_ans: assert property (p_b_ans) else $error("write answer late");
	property p_b_block;
		O_BVALID |-> !O_AWREADY && !O_WREADY;
	endproperty
	a_b_block: assert property (p_b_block) else $error("write open during answer");
	property p_oc_sync;
		(I_OC_WIN == 2'h3) [*8] |-> O_SENSE_SYNC;
	endproperty
	a_oc_sync: assert property (p_oc_sync) else $error("sync low in window");
	property p_fall_on;
		$fell(O_SENSE_SYNC) |-> $past(I_CH_ON, 8) != 2'h0;
	endproperty
	a_fall_on: assert property (p_fall_on) else $error("sync fell while off");
	property p_off_sync;
		(I_CH_ON == 2'h0) [*8] |-> O_SENSE_SYNC;
	endproperty
	a_off_sync: assert property (p_off_sync) else $error("sync low while off");
	property p_pol_hold;
		$changed(O_OFFSET_POLARITY) && I_CH_ON == 2'h0 |=> $stable(O_SENSE_CODE) [*3];
	endproperty
	a_pol_hold: assert property (p_pol_hold) else $error("code moved while off");
	c_fall: cover property ($fell(O_SENSE_SYNC));
	c_rise: cover property ($rose(O_SENSE_SYNC));
	c_pol: cover property ($changed(O_OFFSET_POLARITY));
endmodule

// File: test/shdf_mcu_model.sv
`timescale 1ns/10ps
// ====================
// Controller sampling the sense value
module shdf_mcu_model #(parameter int SW = 12)
(
	// Clock
	input wire logic i_clk,
	// Sample
	input wire logic i_take,
	input wire logic [SW-1:0] i_code,
	output logic [SW-1:0] o_avg
);
	logic [SW-1:0] s0_q;
	logic [SW-1:0] s1_q;
	always_ff @(posedge i_clk)
	begin
		if (i_take)
		begin
			s1_q <= s0_q;
			s0_q <= i_code;
		end
	end
	assign o_avg = SW'(({1'h0, s0_q} + {1'h0, s1_q}) >> 1);
endmodule

// File: test/shdf_tb_top.sv
`timescale 1ns/10ps
`include "shdf_defs.svh"
// ====================
// Bench
module shdf_tb_top;
	logic clk, rstn, awv, wv, bry, arv, rry, nm, thi, take, awr, wr_rdy, bv, arr, rv, sync;
	logic [7:0] awa, ara;
	logic [31:0] wd, rdat, d;
	logic [1:0] chon, ohi, ocw, bresp, rresp, pol;
	logic [11:0] c0, c1, tc, ro, code, avg;
	int fail_count, n_compared, cyc;
	shdf_top #(.SETTLE_CYC(6)) i_shdf_top (.I_CLK_SYS(clk), .I_RSTN(rstn),
		.I_AWADDR(awa), .I_AWVALID(awv), .O_AWREADY(awr), .I_WDATA(wd),
		.I_WSTRB(4'hF), .I_WVALID(wv), .O_WREADY(wr_rdy), .O_BRESP(bresp),
		.O_BVALID(bv), .I_BREADY(bry), .I_ARADDR(ara), .I_ARVALID(arv),
		.O_ARREADY(arr), .O_RDATA(rdat), .O_RRESP(rresp), .O_RVALID(rv),
		.I_RREADY(rry), .I_CH_ON(chon), .I_OUT_HI(ohi), .I_OC_WIN(ocw),
		.I_TEMP_HI(thi), .I_NORMAL_MODE(nm), .I_CUR0(c0), .I_CUR1(c1),
		.I_TEMP_CODE(tc), .I_RAND_OFFSET(ro), .O_SENSE_CODE(code),
		.O_SENSE_SYNC(sync), .O_OFFSET_POLARITY(pol));
	shdf_mcu_model i_shdf_mcu_model (.i_clk(clk), .i_take(take), .i_code(code), .o_avg(avg));
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e)
		begin
			$display("Error at %0t: got %h exp %h", $time, g, e);
			fail_count++;
		end
	endtask
	task end_of_test;
		$display("Compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
		int t;
		t = 0;
		@(posedge clk);
		awa <= a;
		wd <= v;
		awv <= 1'h1;
		wv <= 1'h1;
		bry <= 1'h1;
		do
		begin
			@(posedge clk);
			t++;
			if (awr) awv <= 1'h0;
			if (wr_rdy) wv <= 1'h0;
		end
		while (bv !== 1'h1 && t < 40);
		bry <= 1'h0;
		chk(32'({bv, bresp}), 32'({1'h1, e}));
	endtask
	task rd(input logic [7:0] a, input logic [1:0] e, output logic [31:0] q);
		int t;
		t = 0;
		@(posedge clk);
		ara <= a;
		arv <= 1'h1;
		rry <= 1'h1;
		do
		begin
			@(posedge clk);
			t++;
			if (arr) arv <= 1'h0;
		end
		while (rv !== 1'h1 && t < 40);
		rry <= 1'h0;
		q = rdat;
		chk(32'({rv, rresp}), 32'({1'h1, e}));
	endtask
	task wsync(input logic l);
		int t;
		t = 0;
		while (sync !== l && t < 200)
		begin
			@(posedge clk);
			t++;
		end
		chk(32'(sync), 32'(l));
	endtask
	task sample;
		take <= 1'h1;
		@(posedge clk);
		take <= 1'h0;
		@(posedge clk);
	endtask
	initial
	begin
		clk = 0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fail_count++;
			end_of_test;
		end
	end
	initial
	begin
		{rstn, awv, wv, bry, arv, rry, nm, thi, take, chon, ohi, ocw} = 0;
		{awa, ara, wd, c0, c1, tc, ro} = 0;
		repeat (8) @(posedge clk);
		chk(32'({sync, pol}), 32'h0000_0004);
		rstn <= 1'h1;
		repeat (4) @(posedge clk);
		rd(`SHDF_GCFG_ADDR, 2'h0, d);
		chk(d, 32'h0000_0000);
		rd(8'h40, `SHDF_RESP_SLVERR, d);
		wr(8'h40, 32'h0000_0001, `SHDF_RESP_SLVERR);
		wr(`SHDF_RETRY0_ADDR, 32'h0000_0100, 2'h0);
		wr(`SHDF_GCFG_ADDR, 32'h0000_0005, 2'h0);
		chk(32'(pol), 32'h0000_0001);
		c0 <= 12'h100;
		ro <= 12'h010;
		chon <= 2'h1;
		wsync(1'h0);
		repeat (2) @(posedge clk);
		chk(32'(code), 32'h0000_0110);
		sample;
		chon <= 2'h0;
		c0 <= 12'h3FF;
		wsync(1'h1);
		repeat (8) @(posedge clk);
		chk(32'(code), 32'h0000_0110);
		wr(`SHDF_RETRY0_ADDR, 32'h0000_0000, 2'h0);
		repeat (8) @(posedge clk);
		chk(32'(code), 32'h0000_0110);
		c0 <= 12'h100;
		chon <= 2'h1;
		wsync(1'h0);
		repeat (2) @(posedge clk);
		chk(32'(code), 32'h0000_00F0);
		sample;
		chk(32'(avg), 32'h0000_0100);
		ocw <= 2'h3;
		repeat (10) @(posedge clk);
		chk(32'({sync, code}), 32'h0000_1000);
		ocw <= 2'h0;
		wsync(1'h0);
		chon <= 2'h0;
		wsync(1'h1);
		repeat (4) @(posedge clk);
		chk(32'(code), 32'h0000_00F0);
		wr(`SHDF_GCFG_ADDR, 32'h0000_0006, 2'h0);
		repeat (8) @(posedge clk);
		chk(32'(code), 32'h0000_0000);
		tc <= 12'h2A5;
		wr(`SHDF_GCFG_ADDR, 32'h0000_0003, 2'h0);
		repeat (8) @(posedge clk);
		chk(32'({sync, code}), 32'h0000_12A5);
		wr(`SHDF_GCFG_ADDR, 32'h0000_0005, 2'h0);
		chon <= 2'h1;
		wsync(1'h0);
		repeat (2) @(posedge clk);
		chk(32'(code), 32'h0000_00F0);
		for (int i = 0; i < 4; i++)
		begin
			ohi <= 2'(i);
			repeat (6) @(posedge clk);
			rd(`SHDF_STATUS_ADDR, 2'h0, d);
			chk(32'(d[1:0]), 32'(i));
		end
		thi <= 1'h1;
		repeat (8) @(posedge clk);
		rd(`SHDF_FAULT_ADDR, 2'h0, d);
		chk(32'(d[`SHDF_FAULT_OTW]), 32'h0000_0000);
		nm <= 1'h1;
		repeat (8) @(posedge clk);
		rd(`SHDF_FAULT_ADDR, 2'h0, d);
		chk(32'(d[`SHDF_FAULT_OTW]), 32'h0000_0001);
		rd(`SHDF_FAULT_ADDR, 2'h0, d);
		chk(32'(d[`SHDF_FAULT_OTW]), 32'h0000_0001);
		thi <= 1'h0;
		repeat (8) @(posedge clk);
		rd(`SHDF_FAULT_ADDR, 2'h0, d);
		chk(32'(d[`SHDF_FAULT_OTW]), 32'h0000_0001);
		rd(`SHDF_FAULT_ADDR, 2'h0, d);
		chk(32'(d[`SHDF_FAULT_OTW]), 32'h0000_0000);
		end_of_test;
	end
endmodule
bind shdf_top shdf_top_assertions #(.SW(SW)) i_shdf_top_assertions (.*);
